/* File: design/tfmt_averager.sv */
module tfmt_averager #(
  parameter int LOG2_N = tfmt_pkg::AVG_LOG2
) (
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               bypass,
  input  wire logic                               restart,
  input  wire logic                               sample_valid,
  input  wire logic signed [tfmt_pkg::CODE_W-1:0] sample,
  output logic                                    avg_valid,
  output logic signed [tfmt_pkg::CODE_W-1:0]      avg
);
  import tfmt_pkg::*;

  if (LOG2_N < 1 || LOG2_N > 8) begin : g_bad
    $error("averager depth out of range");
  end

  localparam int ACC_W = CODE_W + LOG2_N;

  logic [LOG2_N-1:0]       cnt;
  logic signed [ACC_W-1:0] acc;
  logic signed [ACC_W-1:0] next_acc;

  assign next_acc = acc + ACC_W'(sample);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt       <= '0;
      acc       <= '0;
      avg_valid <= 1'b0;
      avg       <= '0;
    end else begin
      avg_valid <= 1'b0;
      if (restart) begin
        cnt <= '0;
        acc <= '0;
      end else if (sample_valid) begin
        if (bypass) begin
          avg       <= sample;
          avg_valid <= 1'b1;
        end else if (cnt == '1) begin
          avg       <= CODE_W'(next_acc >>> LOG2_N);
          avg_valid <= 1'b1;
          cnt       <= '0;
          acc       <= '0;
        end else begin
          cnt <= cnt + 1'b1;
          acc <= next_acc;
        end
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_avg_last;
    (sample_valid && !bypass && !restart && cnt == '1) |=> avg_valid;
  endproperty
  a_avg_last: assert property (p_avg_last) else $error("no average after last sample");

  property p_avg_early;
    (sample_valid && !bypass && cnt != '1) |=> !avg_valid;
  endproperty
  a_avg_early: assert property (p_avg_early) else $error("average before full count");
endmodule

/* File: design/tfmt_excite_seq.sv */
module tfmt_excite_seq #(
  parameter int FIRST_MULT  = 8,
  parameter int SECOND_MULT = 16,
  parameter int SAMPLE_W    = 12,
  parameter int RES_SHIFT   = 0
) (
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               run,
  input  wire logic                               sample_valid,
  input  wire logic signed [SAMPLE_W-1:0]         sample,
  output tfmt_pkg::tfmt_exc_e                     excite_level,
  output logic                                    result_valid,
  output logic signed [tfmt_pkg::CODE_W-1:0]      result
);
  import tfmt_pkg::*;

  if (FIRST_MULT < 2 || SECOND_MULT <= FIRST_MULT || SECOND_MULT > 256 ||
      SAMPLE_W < 10 || SAMPLE_W > 20 || RES_SHIFT < 0 || RES_SHIFT > 16) begin : g_bad
    $error("excitation parameters out of range");
  end

  localparam int D_W = SAMPLE_W + 1;
  localparam int P_W = D_W + 10;
  localparam logic signed [P_W-1:0] WT_FIRST  = P_W'(FIRST_MULT - 1);
  localparam logic signed [P_W-1:0] WT_SECOND = P_W'(SECOND_MULT - 1);

  typedef enum logic [2:0] {SQ_IDLE, SQ_BASE1, SQ_HIGH1, SQ_BASE2, SQ_HIGH2, SQ_CALC} tfmt_seq_e;

  tfmt_seq_e               st;
  logic signed [SAMPLE_W-1:0] base_smp;
  logic signed [D_W-1:0]   diff1;
  logic signed [D_W-1:0]   diff2;
  logic signed [P_W-1:0]   combo;

  // Series resistance term scales with (multiple - 1); weighting cancels it
  assign combo = (P_W'(diff1) * WT_SECOND - P_W'(diff2) * WT_FIRST) >>> RES_SHIFT;

  always_comb begin
    case (st)
      SQ_HIGH1: excite_level = TFMT_EXC_FIRST;
      SQ_HIGH2: excite_level = TFMT_EXC_SECOND;
      default:  excite_level = TFMT_EXC_BASE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st           <= SQ_IDLE;
      base_smp     <= '0;
      diff1        <= '0;
      diff2        <= '0;
      result_valid <= 1'b0;
      result       <= '0;
    end else begin
      result_valid <= 1'b0;
      case (st)
        SQ_IDLE: begin
          if (run && !result_valid) begin
            st <= SQ_BASE1;
          end
        end
        SQ_BASE1: begin
          if (sample_valid) begin
            base_smp <= sample;
            st       <= SQ_HIGH1;
          end
        end
        SQ_HIGH1: begin
          if (sample_valid) begin
            diff1 <= D_W'(sample) - D_W'(base_smp);
            st    <= SQ_BASE2;
          end
        end
        SQ_BASE2: begin
          if (sample_valid) begin
            base_smp <= sample;
            st       <= SQ_HIGH2;
          end
        end
        SQ_HIGH2: begin
          if (sample_valid) begin
            diff2 <= D_W'(sample) - D_W'(base_smp);
            st    <= SQ_CALC;
          end
        end
        SQ_CALC: begin
          result       <= CODE_W'(combo);
          result_valid <= 1'b1;
          st           <= SQ_IDLE;
        end
        default: st <= SQ_IDLE;
      endcase
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_first_pair;
    (excite_level == TFMT_EXC_BASE && st == SQ_BASE1 && sample_valid)
      ##1 (excite_level == TFMT_EXC_FIRST);
  endsequence

  property p_first_step;
    (st == SQ_BASE1 && sample_valid) |-> s_first_pair;
  endproperty
  a_first_step: assert property (p_first_step) else $error("first multiple not applied");

  property p_second_step;
    (st == SQ_BASE2 && sample_valid) |=> excite_level == TFMT_EXC_SECOND;
  endproperty
  a_second_step: assert property (p_second_step) else $error("second multiple not applied");

  property p_back_to_base;
    (st == SQ_HIGH1 && sample_valid) |=> excite_level == TFMT_EXC_BASE ##1 st == SQ_BASE2;
  endproperty
  a_back_to_base: assert property (p_back_to_base) else $error("base level not restored");
endmodule

/* File: design/tfmt_result_formatter.sv */
module tfmt_result_formatter #(
  parameter int ADDR_W      = 12,
  parameter int SAMPLE_W    = 12,
  parameter int FIRST_MULT  = 8,
  parameter int SECOND_MULT = 16,
  parameter int RES_SHIFT   = 0
) (
  input  wire logic                               pclk,
  input  wire logic                               presetn,
  input  wire logic                               psel,
  input  wire logic                               penable,
  input  wire logic                               pwrite,
  input  wire logic [ADDR_W-1:0]                  paddr,
  input  wire logic [31:0]                        pwdata,
  output logic [31:0]                             prdata,
  output logic                                    pready,
  output logic                                    pslverr,
  input  wire logic                               local_valid,
  input  wire logic signed [tfmt_pkg::CODE_W-1:0] local_code,
  input  wire logic                               sample_valid,
  input  wire logic signed [SAMPLE_W-1:0]         sample,
  output tfmt_pkg::tfmt_exc_e                     excite_level,
  output logic                                    remote_sel
);
  import tfmt_pkg::*;

  if (ADDR_W < 11 || ADDR_W > 32) begin : g_bad
    $error("address width out of range");
  end

  logic [1:0]        ch;
  logic              ctrl_ext;
  logic              ctrl_avg_off;
  logic              frozen;
  logic [NUM_CH-1:0] rd_seen;
  logic [7:0]        ofs    [NUM_CH];
  logic [CODE_W-1:0] shadow [NUM_CH];
  logic [CODE_W-1:0] vis    [NUM_CH];

  logic                     seq_valid;
  logic signed [CODE_W-1:0] seq_code;
  logic                     avg_in_valid;
  logic signed [CODE_W-1:0] avg_in;
  logic                     avg_valid;
  logic signed [CODE_W-1:0] avg;
  logic                     ctrl_wr;

  // Bus decode
  logic [7:0]        idx;
  logic              addr_ok;
  logic              setup;
  logic              access;
  logic              rd_hit;
  logic              wr_hit;
  logic [31:0]       rd_word;
  logic [NUM_CH-1:0] val_mask;

  assign idx     = paddr[9:2];
  assign addr_ok = (paddr[1:0] == 2'h0) && (paddr[ADDR_W-1:10] == '0);
  assign setup   = psel && !penable;
  assign access  = psel && penable;
  assign pready  = 1'b1;

  always_comb begin
    rd_word  = 32'h0000_0000;
    rd_hit   = addr_ok;
    wr_hit   = 1'b0;
    val_mask = '0;
    case (idx)
      IDX_REMOTE1_VAL: begin
        rd_word[7:0] = vis[CH_REMOTE1][CODE_W-1:FRAC_W];
        val_mask[CH_REMOTE1] = 1'b1;
      end
      IDX_LOCAL_VAL: begin
        rd_word[7:0] = vis[CH_LOCAL][CODE_W-1:FRAC_W];
        val_mask[CH_LOCAL] = 1'b1;
      end
      IDX_REMOTE2_VAL: begin
        rd_word[7:0] = vis[CH_REMOTE2][CODE_W-1:FRAC_W];
        val_mask[CH_REMOTE2] = 1'b1;
      end
      IDX_FRACTION: begin
        rd_word[FRAC_REMOTE2_LSB +: FRAC_W] = vis[CH_REMOTE2][FRAC_W-1:0];
        rd_word[FRAC_LOCAL_LSB +: FRAC_W]   = vis[CH_LOCAL][FRAC_W-1:0];
        rd_word[FRAC_REMOTE1_LSB +: FRAC_W] = vis[CH_REMOTE1][FRAC_W-1:0];
      end
      IDX_REMOTE1_OFS: begin
        rd_word[7:0] = ofs[CH_REMOTE1];
        wr_hit       = addr_ok;
      end
      IDX_LOCAL_OFS: begin
        rd_word[7:0] = ofs[CH_LOCAL];
        wr_hit       = addr_ok;
      end
      IDX_REMOTE2_OFS: begin
        rd_word[7:0] = ofs[CH_REMOTE2];
        wr_hit       = addr_ok;
      end
      IDX_CONTROL: begin
        rd_word[CTRL_EXT_BIT]     = ctrl_ext;
        rd_word[CTRL_AVG_OFF_BIT] = ctrl_avg_off;
        wr_hit                    = addr_ok;
      end
      IDX_STATUS: begin
        rd_word[1:0] = ch;
        rd_word[2]   = frozen;
      end
      default: rd_hit = 1'b0;
    endcase
    if (!addr_ok) begin
      rd_word = 32'h0000_0000;
    end
  end

  assign pslverr = access && !(pwrite ? wr_hit : rd_hit);
  assign ctrl_wr = access && pwrite && wr_hit && idx == IDX_CONTROL;

  // Read data is captured in the setup cycle and stands through the access
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
    end else if (setup) begin
      prdata <= pwrite ? 32'h0000_0000 : rd_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_ext     <= 1'b0;
      ctrl_avg_off <= 1'b0;
    end else if (ctrl_wr) begin
      ctrl_ext     <= pwdata[CTRL_EXT_BIT];
      ctrl_avg_off <= pwdata[CTRL_AVG_OFF_BIT];
    end
  end

  // Freeze on fraction read, release once every value register is read
  logic              rd_access;
  logic [NUM_CH-1:0] next_seen;

  assign rd_access = access && !pwrite && addr_ok;
  assign next_seen = rd_seen | (rd_access ? val_mask : '0);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      frozen  <= 1'b0;
      rd_seen <= '0;
    end else if (!frozen) begin
      if (rd_access && idx == IDX_FRACTION) begin
        frozen  <= 1'b1;
        rd_seen <= '0;
      end
    end else if (&next_seen) begin
      frozen  <= 1'b0;
      rd_seen <= '0;
    end else begin
      rd_seen <= next_seen;
    end
  end

  // Channel scan: remote one, local, remote two
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ch <= CH_REMOTE1;
    end else if (avg_valid) begin
      ch <= (ch == CH_REMOTE2) ? CH_REMOTE1 : ch + 2'h1;
    end
  end

  assign remote_sel   = (ch == CH_REMOTE2);
  assign avg_in_valid = (ch == CH_LOCAL) ? local_valid : seq_valid;
  assign avg_in       = (ch == CH_LOCAL) ? local_code : seq_code;

  tfmt_excite_seq #(
    .FIRST_MULT  (FIRST_MULT),
    .SECOND_MULT (SECOND_MULT),
    .SAMPLE_W    (SAMPLE_W),
    .RES_SHIFT   (RES_SHIFT)
  ) u_seq (
    .pclk         (pclk),
    .presetn      (presetn),
    .run          ((ch != CH_LOCAL) && !avg_valid),
    .sample_valid (sample_valid),
    .sample       (sample),
    .excite_level (excite_level),
    .result_valid (seq_valid),
    .result       (seq_code)
  );

  tfmt_averager #(
    .LOG2_N (AVG_LOG2)
  ) u_avg (
    .pclk         (pclk),
    .presetn      (presetn),
    .bypass       (ctrl_avg_off),
    .restart      (ctrl_wr),
    .sample_valid (avg_in_valid),
    .sample       (avg_in),
    .avg_valid    (avg_valid),
    .avg          (avg)
  );

  // Offset in half degrees becomes quarter-degree steps
  logic [7:0]         ofs_cur;
  logic signed [11:0] adj;
  logic signed [11:0] ext_val;
  logic [CODE_W-1:0]  next_code;

  assign ofs_cur = ofs[ch];
  assign adj     = {{2{avg[CODE_W-1]}}, avg} + {{3{ofs_cur[7]}}, ofs_cur, 1'b0};
  assign ext_val = adj + EXT_BIAS_CODE;

  always_comb begin
    if (ctrl_ext) begin
      if (ext_val < 0) begin
        next_code = CODE_RESET;
      end else if (ext_val > EXT_MAX) begin
        next_code = EXT_MAX[CODE_W-1:0];
      end else begin
        next_code = ext_val[CODE_W-1:0];
      end
    end else begin
      if (adj < TWOS_MIN) begin
        next_code = TWOS_MIN[CODE_W-1:0];
      end else if (adj > TWOS_MAX) begin
        next_code = TWOS_MAX[CODE_W-1:0];
      end else begin
        next_code = adj[CODE_W-1:0];
      end
    end
  end

  for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        ofs[c] <= OFFSET_RESET;
      end else if (access && pwrite && wr_hit && idx == IDX_REMOTE1_OFS + 8'(c)) begin
        ofs[c] <= pwdata[7:0];
      end
    end

    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        shadow[c] <= CODE_RESET;
      end else if (avg_valid && ch == 2'(c)) begin
        shadow[c] <= next_code;
      end
    end

    // Whole 10-bit word moves at once; held while frozen or bus selected
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        vis[c] <= CODE_RESET;
      end else if (!frozen && !psel) begin
        vis[c] <= shadow[c];
      end
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  property p_freeze;
    (rd_access && idx == IDX_FRACTION && !frozen) |=> frozen;
  endproperty
  a_freeze: assert property (p_freeze) else $error("fraction read did not freeze");

  property p_release;
    (frozen && rd_access && (&next_seen)) |=> !frozen;
  endproperty
  a_release: assert property (p_release) else $error("freeze not released");

  property p_frozen_hold;
    frozen |=> $stable(vis[CH_LOCAL]) && $stable(vis[CH_REMOTE1]) && $stable(vis[CH_REMOTE2]);
  endproperty
  a_frozen_hold: assert property (p_frozen_hold) else $error("value changed while frozen");

  property p_pair_update;
    (!frozen && !psel) |=> vis[CH_LOCAL] == $past(shadow[CH_LOCAL]);
  endproperty
  a_pair_update: assert property (p_pair_update) else $error("local word not moved whole");

  property p_local_read;
    (setup && !pwrite && addr_ok && idx == IDX_LOCAL_VAL)
      |=> prdata == {24'h000000, $past(vis[CH_LOCAL][CODE_W-1:FRAC_W])};
  endproperty
  a_local_read: assert property (p_local_read) else $error("local upper byte wrong");

  property p_frac_read;
    (setup && !pwrite && addr_ok && idx == IDX_FRACTION)
      |=> prdata[7:6] == $past(vis[CH_REMOTE2][1:0]) && prdata[5:4] == $past(vis[CH_LOCAL][1:0])
          && prdata[3:2] == $past(vis[CH_REMOTE1][1:0]) && prdata[1:0] == 2'h0;
  endproperty
  a_frac_read: assert property (p_frac_read) else $error("fraction layout wrong");

  property p_ext_points;
    (avg_valid && ctrl_ext && adj == 12'sh000) |-> next_code[CODE_W-1:FRAC_W] == 8'h40;
  endproperty
  a_ext_points: assert property (p_ext_points) else $error("extended zero code wrong");

  property p_ext_top;
    (avg_valid && ctrl_ext && adj == 12'sh2FC) |-> next_code == 10'h3FC;
  endproperty
  a_ext_top: assert property (p_ext_top) else $error("extended 191 code wrong");

  property p_ext_floor;
    (avg_valid && ctrl_ext && ext_val < 0) |-> next_code == 10'h000;
  endproperty
  a_ext_floor: assert property (p_ext_floor) else $error("extended floor clamp wrong");

  property p_twos_floor;
    (avg_valid && !ctrl_ext && adj < TWOS_MIN) |-> next_code == 10'h200;
  endproperty
  a_twos_floor: assert property (p_twos_floor) else $error("twos floor clamp wrong");

  property p_twos_ceil;
    (avg_valid && !ctrl_ext && adj > TWOS_MAX) |-> next_code == 10'h1FF;
  endproperty
  a_twos_ceil: assert property (p_twos_ceil) else $error("twos ceiling clamp wrong");

  property p_offset_store;
    (avg_valid && ch == CH_LOCAL && !ctrl_ext && avg == 10'sh000 && ofs_cur == 8'h02)
      |=> shadow[CH_LOCAL] == 10'h004;
  endproperty
  a_offset_store: assert property (p_offset_store) else $error("offset not applied");

  property p_unmapped;
    (access && !pwrite && !rd_hit) |-> pslverr && pready;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not refused");
endmodule

/* File: include/tfmt_pkg.sv */
package tfmt_pkg;

  localparam int unsigned CODE_W   = 10;
  localparam int unsigned FRAC_W   = 2;
  localparam int unsigned NUM_CH   = 3;
  localparam int unsigned AVG_LOG2 = 4;

  // Register indices; byte address is four times the index
  localparam logic [7:0] IDX_REMOTE1_VAL = 8'h25;
  localparam logic [7:0] IDX_LOCAL_VAL   = 8'h26;
  localparam logic [7:0] IDX_REMOTE2_VAL = 8'h27;
  localparam logic [7:0] IDX_REMOTE1_OFS = 8'h70;
  localparam logic [7:0] IDX_LOCAL_OFS   = 8'h71;
  localparam logic [7:0] IDX_REMOTE2_OFS = 8'h72;
  localparam logic [7:0] IDX_FRACTION    = 8'h77;
  localparam logic [7:0] IDX_CONTROL     = 8'h7D;
  localparam logic [7:0] IDX_STATUS      = 8'h7E;

  // Field positions
  localparam int unsigned FRAC_REMOTE2_LSB = 6;
  localparam int unsigned FRAC_LOCAL_LSB   = 4;
  localparam int unsigned FRAC_REMOTE1_LSB = 2;
  localparam int unsigned CTRL_EXT_BIT     = 0;
  localparam int unsigned CTRL_AVG_OFF_BIT = 1;

  // Reset values
  localparam logic [7:0]        OFFSET_RESET = 8'h00;
  localparam logic [CODE_W-1:0] CODE_RESET   = 10'h000;

  // Channel numbers, in register order
  localparam logic [1:0] CH_REMOTE1 = 2'h0;
  localparam logic [1:0] CH_LOCAL   = 2'h1;
  localparam logic [1:0] CH_REMOTE2 = 2'h2;

  // Coding limits in quarter degrees
  localparam int unsigned       EXT_BIAS_DEGC = 64;
  localparam logic signed [11:0] EXT_BIAS_CODE = 12'(EXT_BIAS_DEGC * 4);
  localparam logic signed [11:0] TWOS_MIN      = 12'shE00;
  localparam logic signed [11:0] TWOS_MAX      = 12'sh1FF;
  localparam logic signed [11:0] EXT_MAX       = 12'sh3FF;

  typedef enum logic [1:0] {TFMT_EXC_BASE, TFMT_EXC_FIRST, TFMT_EXC_SECOND} tfmt_exc_e;

endpackage

/* File: tb/tfmt_diode_model.sv */
module tfmt_diode_model (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire tfmt_pkg::tfmt_exc_e excite_level,
  input  wire logic signed [9:0]   code,
  input  wire logic [2:0]          gap,
  output logic                     sample_valid,
  output logic signed [11:0]       sample
);
  timeunit 1ns;
  timeprecision 1ns;
  import tfmt_pkg::*;
  logic [2:0] cnt;
  // Second step is twice the first, so the weighted difference equals code
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt <= 3'h0;
      sample_valid <= 1'b0;
      sample <= 12'sh064;
    end else begin
      sample_valid <= (cnt == gap);
      cnt <= (cnt == gap) ? 3'h0 : cnt + 3'h1;
      if (cnt == gap) begin
        case (excite_level)
          TFMT_EXC_FIRST:  sample <= 12'sh064 + 12'(code);
          TFMT_EXC_SECOND: sample <= 12'sh064 + 12'(code) * 12'sd2;
          default:         sample <= 12'sh064;
        endcase
      end else begin
        sample <= ~sample;
      end
    end
  end
endmodule

/* File: tb/tfmt_result_formatter_tb_top.sv */
module tfmt_result_formatter_tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import tfmt_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic local_valid, sample_valid, remote_sel, ext_r;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, lf, r;
  logic signed [9:0] local_code, rcode, ca, cc;
  logic signed [11:0] sample;
  logic [2:0] gap, lcnt;
  logic [7:0] ofs [3];
  logic [9:0] e;
  logic err;
  tfmt_exc_e excite_level;
  int failures, num_checks;

  tfmt_result_formatter DUT (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .local_valid(local_valid), .local_code(local_code),
    .sample_valid(sample_valid), .sample(sample), .excite_level(excite_level),
    .remote_sel(remote_sel));
  tfmt_diode_model diode (.pclk(pclk), .presetn(presetn), .excite_level(excite_level),
    .code(rcode), .gap(gap), .sample_valid(sample_valid), .sample(sample));
  assign rcode = remote_sel ? cc : ca;

  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  always @(posedge pclk) begin
    lcnt <= lcnt + 3'h1;
    local_valid <= (lcnt == 3'h3);
  end

  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  function automatic logic [9:0] fmt(input logic signed [9:0] c, input logic [7:0] o,
                                     input logic x);
    int v;
    v = c + 2 * $signed(o) + (x ? 256 : 0);
    if (v > (x ? 1023 : 511)) v = x ? 1023 : 511;
    if (v < (x ? 0 : -512)) v = x ? 0 : -512;
    return 10'(v);
  endfunction

  task automatic print_verdict;
    if (failures == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      failures++;
      $display("FAIL %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic apb(input logic wr, input logic [7:0] idx, input logic [7:0] wd,
                     output logic [31:0] rd, output logic er);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, wd};
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      failures++;
      print_verdict();
    end
  endtask
  task automatic expect_all(input int tries);
    logic [9:0] e1, el, e2;
    logic [31:0] f, v1, vl, v2;
    int n;
    e1 = fmt(ca, ofs[0], ext_r);
    el = fmt(local_code, ofs[1], ext_r);
    e2 = fmt(cc, ofs[2], ext_r);
    n = 0;
    do begin
      apb(1'b0, IDX_FRACTION, 8'h00, f, err);
      apb(1'b0, IDX_REMOTE1_VAL, 8'h00, v1, err);
      apb(1'b0, IDX_LOCAL_VAL, 8'h00, vl, err);
      apb(1'b0, IDX_REMOTE2_VAL, 8'h00, v2, err);
      n++;
    end while ({v1[7:0], vl[7:0], v2[7:0], f[7:0]} !==
               {e1[9:2], el[9:2], e2[9:2], e2[1:0], el[1:0], e1[1:0], 2'b00} && n < tries);
    chk("remote1", v1, {24'h0, e1[9:2]});
    chk("local", vl, {24'h0, el[9:2]});
    chk("remote2", v2, {24'h0, e2[9:2]});
    chk("fraction", f, {24'h0, e2[1:0], el[1:0], e1[1:0], 2'b00});
  endtask

  initial begin
    {psel, penable, pwrite, paddr, pwdata, local_code, ca, cc} = '0;
    {lcnt, local_valid, failures, num_checks, ext_r} = '0;
    gap = 3'h1;
    lf = 32'hB80D;
    presetn = 1'b0;
    repeat (12) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, IDX_LOCAL_VAL, 8'h00, r, err);
    chk("local reset", r, 32'h0);
    apb(1'b0, IDX_REMOTE1_OFS, 8'h00, r, err);
    chk("offset reset", r, 32'h0);
    apb(1'b0, 8'h30, 8'h00, r, err);
    chk("unmapped error", {31'h0, err}, 32'h1);
    apb(1'b1, IDX_LOCAL_VAL, 8'h5A, r, err);
    chk("value write error", {31'h0, err}, 32'h1);
    for (int i = 0; i < 9; i++) begin
      lf = lfsr(lfsr(lf));
      gap <= 3'h1 + 3'(lf[13:12]);
      case (i)
        0: begin ca <= 10'sh000; local_code <= 10'sh000; cc <= 10'sh000; ext_r = 1'b0;
                 ofs = '{8'h00, 8'h02, 8'h00}; end
        1: begin ca <= -10'sd256; local_code <= 10'sh000; cc <= 10'sh1FE; ext_r = 1'b1;
                 ofs = '{8'h00, 8'h00, 8'h7F}; end
        2: begin ca <= 10'sh1FF; local_code <= 10'sh200; cc <= 10'sh029; ext_r = 1'b0;
                 ofs = '{8'h7F, 8'h80, 8'h00}; end
        default: begin
          ca         <= lf[9:0];
          local_code <= lf[19:10];
          cc         <= lf[29:20];
          ext_r      = lf[30];
          ofs        = '{lf[7:0], lf[15:8], lf[23:16]};
        end
      endcase
      for (int k = 0; k < 3; k++) apb(1'b1, IDX_REMOTE1_OFS + 8'(k), ofs[k], r, err);
      apb(1'b1, IDX_CONTROL, {6'h00, (i < 7), ext_r}, r, err);
      apb(1'b0, IDX_CONTROL, 8'h00, r, err);
      chk("control", r, {30'h0, (i < 7), ext_r});
      expect_all(i < 7 ? 80 : 500);
    end
    e = fmt(local_code, ofs[1], ext_r);
    apb(1'b0, IDX_FRACTION, 8'h00, r, err);
    local_code <= local_code ^ 10'sh155;
    apb(1'b0, IDX_STATUS, 8'h00, r, err);
    chk("status frozen", {31'h0, r[2]}, 32'h1);
    repeat (1500) @(posedge pclk);
    apb(1'b0, IDX_LOCAL_VAL, 8'h00, r, err);
    chk("frozen local", r, {24'h0, e[9:2]});
    apb(1'b0, IDX_REMOTE1_VAL, 8'h00, r, err);
    apb(1'b0, IDX_REMOTE2_VAL, 8'h00, r, err);
    expect_all(500);
    apb(1'b0, IDX_STATUS, 8'h00, r, err);
    chk("status released", {31'h0, r[2]}, 32'h0);
    print_verdict();
  end
endmodule
